/* core/anaid_adv_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface anaid_adv_if;
	logic [15:0] act_adv;
	logic [1:0]  act_gig;
	logic        an_en;
	logic [1:0]  speed;
	logic        duplex;
	logic [15:0] base_word;
	logic [1:0]  gig_adv;
	logic        forced;
	modport regs (output act_adv, act_gig, an_en, speed, duplex,
		input base_word, gig_adv, forced);
	modport former (input act_adv, act_gig, an_en, speed, duplex,
		output base_word, gig_adv, forced);
endinterface
`default_nettype wire

/* core/anaid_cfg.svh */
`ifndef ANAID_CFG_SVH
`define ANAID_CFG_SVH
// register offsets
`define ANAID_OFF_CTRL      5'h00
`define ANAID_OFF_ID2       5'h03
`define ANAID_OFF_ADV       5'h04
`define ANAID_OFF_GIG       5'h09
`define ANAID_OFF_STAT      5'h11
// control word fields
`define ANAID_CTL_SWRST     15
`define ANAID_CTL_SPD_LSB   13
`define ANAID_CTL_AN_EN     12
`define ANAID_CTL_PWRDN     11
`define ANAID_CTL_RESTART   9
`define ANAID_CTL_DUPLEX    8
`define ANAID_CTL_SPD_MSB   6
`define ANAID_CTL_RST       16'h1140
// advertisement fields
`define ANAID_ADV_NP        15
`define ANAID_ADV_ACK       14
`define ANAID_ADV_RF        13
`define ANAID_ADV_RSVD      12
`define ANAID_ADV_ASYM      11
`define ANAID_ADV_PAUSE     10
`define ANAID_ADV_T4        9
`define ANAID_ADV_TXFD      8
`define ANAID_ADV_WMASK     16'hBF00
`define ANAID_ADV_RST       16'h0100
`define ANAID_ADV_T4_MASK   16'h0200
// gigabit ability fields, bits 9:8
`define ANAID_GIG_LSB       8
`define ANAID_GIG_RST       2'h3
// generated next pages
`define ANAID_PG_MP         13
`define ANAID_PG_MSG_GIG    11'h008
`define ANAID_PG_UNF_FD     4
`define ANAID_PG_UNF_HD     3
// status fields
`define ANAID_ST_LINK       0
`define ANAID_ST_PEND       1
`define ANAID_ST_FORCED     2
`endif

/* core/anaid_former.sv */
`timescale 1ns/100ps
`default_nettype none
`include "anaid_cfg.svh"
module anaid_former
(
	anaid_adv_if.former adv
);
	////////////////////////////////////////////////////////////////
	// forced 1000 still negotiates, with one gig ability only
	assign adv.forced = ~adv.an_en && (adv.speed == 2'h2);
	always_comb
	begin
		adv.base_word = adv.act_adv;
		adv.base_word[`ANAID_ADV_ACK] = 1'b0;
		adv.gig_adv = adv.act_gig;
		if (adv.forced)
		begin
			adv.base_word[`ANAID_ADV_TXFD:5] = 4'h0;
			adv.gig_adv = adv.duplex ? 2'h2 : 2'h1;
		end
		// gig ability needs next pages, so request them on its own
		if (adv.gig_adv != 2'h0)
			adv.base_word[`ANAID_ADV_NP] = 1'b1;
	end
endmodule
`default_nettype wire

/* core/anaid_pend.sv */
`timescale 1ns/100ps
`default_nettype none
`include "anaid_cfg.svh"
module anaid_pend
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic swrst_in,
	input  wire logic restart_in,
	input  wire logic pwrdn_in,
	input  wire logic link_in,
	output logic      apply_all_out,
	output logic      apply_keep_out
);
	logic pwrdn_prev;
	logic link_prev;
	////////////////////////////////////////////////////////////////
	// previous levels for edge detection
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			pwrdn_prev <= 1'b0;
			link_prev  <= 1'b0;
		end
		else
		begin
			pwrdn_prev <= pwrdn_in;
			link_prev  <= link_in;
		end
	end
	////////////////////////////////////////////////////////////////
	// non-reset triggers: restart, leaving power-down, link loss
	assign apply_keep_out = restart_in | (pwrdn_prev & ~pwrdn_in) | (link_prev & ~link_in);
	assign apply_all_out  = apply_keep_out | swrst_in;
endmodule
`default_nettype wire

/* core/anaid_pkg.sv */
package anaid_pkg;
	// page sequencer position
	typedef enum logic [1:0] {
		anaid_pg_base,
		anaid_pg_msg,
		anaid_pg_unf,
		anaid_pg_sw
	} anaid_pg_t;
	typedef logic [15:0] anaid_word_t;
endpackage

/* core/anaid_regs.sv */
// Function
// - written advertisement waits until reset, restart, power-up or link loss applies it
// - gigabit ability makes the device send its own next pages
// - bit 13 sets remote fault in the sent base word
// - reserved bit 12 is read/write, resets to zero
// - bit 11 advertises asymmetric pause, resets to zero
// - bit 10 advertises pause in the attached MAC, resets to zero
// - bit 9 resets to zero and survives a software reset; a restart, power-up or link loss in the same cycle applies the written bit 9
// - forced 1000 without negotiation still negotiates one duplex of gigabit
// - forced 1000 ignores 10/100 and gigabit advertisement bits; the code clears only bits 8:5 and keeps bit 9 (100BASE-T4)
// - identifier word two is read-only: vendor bits, model, revision
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "anaid_cfg.svh"
module anaid_regs
#(
	parameter logic [5:0] VENDOR_LOW = 6'h2A, // arbitrary value
	parameter logic [5:0] MODEL      = 6'h15, // arbitrary value
	parameter logic [3:0] REVISION   = 4'h1   // arbitrary value
)
(
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [4:0]  addr_in,
	input  wire logic [15:0] wr_data_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rd_data_out,
	input  wire logic        copper_link_in,
	input  wire logic        page_req_in,
	output logic      [15:0] tx_word_out,
	output logic             tx_valid_out,
	output logic      [15:0] base_word_out,
	output logic      [1:0]  gig_adv_out,
	output logic             forced_out,
	output logic             applied_out,
	output logic             swrst_out
);
	////////////////////////////////////////////////////////////////
	// declarations
	anaid_adv_if adv ();
	logic [15:0] ctrl;
	logic        swrst_pulse;
	logic        restart_pulse;
	// pending copy as written, active copy as advertised
	logic [15:0] wr_adv;
	logic [15:0] next_wr_adv;
	logic [15:0] act_adv;
	logic [1:0]  wr_gig;
	logic [1:0]  next_wr_gig;
	logic [1:0]  act_gig;
	logic        link_meta;
	logic        link_sync;
	logic        apply_all;
	logic        apply_keep;
	logic        pending;
	logic [15:0] next_rd;
	anaid_pkg::anaid_pg_t pg_state;
	anaid_pkg::anaid_pg_t next_pg_state;
	anaid_pkg::anaid_word_t next_tx_word;

	////////////////////////////////////////////////////////////////
	// address decode shared by writes and reads
	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////
	// copper link comes from the analog side: two flops first
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			link_meta <= 1'b0;
			link_sync <= 1'b0;
		end
		else
		begin
			link_meta <= copper_link_in;
			link_sync <= link_meta;
		end
	end

	////////////////////////////////////////////////////////////////
	// control word; reset and restart bits self-clear
	// speed, duplex and power-down act at once; only the advertisement waits
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ctrl <= `ANAID_CTL_RST;
		else if (wr_in && hit(addr_in, `ANAID_OFF_CTRL))
		begin
			ctrl <= wr_data_in;
			ctrl[`ANAID_CTL_SWRST]   <= 1'b0;
			ctrl[`ANAID_CTL_RESTART] <= 1'b0;
		end
	end

	// one-cycle command pulses taken from the write itself
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			swrst_pulse   <= 1'b0;
			restart_pulse <= 1'b0;
		end
		else
		begin
			swrst_pulse   <= wr_in && hit(addr_in, `ANAID_OFF_CTRL)
				&& wr_data_in[`ANAID_CTL_SWRST];
			restart_pulse <= wr_in && hit(addr_in, `ANAID_OFF_CTRL)
				&& wr_data_in[`ANAID_CTL_RESTART];
		end
	end

	////////////////////////////////////////////////////////////////
	// trigger detection
	anaid_pend i_anaid_pend
	(
		.clk_in         (clk_in),
		.rst_n_in       (rst_n_in),
		.swrst_in       (swrst_pulse),
		.restart_in     (restart_pulse),
		.pwrdn_in       (ctrl[`ANAID_CTL_PWRDN]),
		.link_in        (link_sync),
		.apply_all_out  (apply_all),
		.apply_keep_out (apply_keep)
	);

	////////////////////////////////////////////////////////////////
	// written (pending) advertisement values
	always_comb
	begin
		next_wr_adv = wr_adv;
		next_wr_gig = wr_gig;
		if (wr_in && hit(addr_in, `ANAID_OFF_ADV))
			next_wr_adv = wr_data_in & `ANAID_ADV_WMASK;
		if (wr_in && hit(addr_in, `ANAID_OFF_GIG))
			next_wr_gig = wr_data_in[`ANAID_GIG_LSB +: 2];
	end

	// pending registers survive a software reset; only a hardware reset clears them
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			wr_adv <= `ANAID_ADV_RST;
			wr_gig <= `ANAID_GIG_RST;
		end
		else
		begin
			wr_adv <= next_wr_adv;
			wr_gig <= next_wr_gig;
		end
	end

	////////////////////////////////////////////////////////////////
	// active values change only on a trigger; a write in the same
	// cycle as the trigger is taken along, except its bit 9 on a software reset alone
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			act_adv <= `ANAID_ADV_RST;
			act_gig <= `ANAID_GIG_RST;
		end
		else if (apply_keep)
		begin
			act_adv <= next_wr_adv;
			act_gig <= next_wr_gig;
		end
		else if (apply_all)
		begin
			// software reset keeps the active T4 bit as it was
			act_adv <= (next_wr_adv & ~`ANAID_ADV_T4_MASK)
				| (act_adv & `ANAID_ADV_T4_MASK);
			act_gig <= next_wr_gig;
		end
	end

	// differs while a write still waits for its trigger
	assign pending = (wr_adv != act_adv) || (wr_gig != act_gig);

	////////////////////////////////////////////////////////////////
	// advertisement former
	assign adv.act_adv = act_adv;
	assign adv.act_gig = act_gig;
	assign adv.an_en   = ctrl[`ANAID_CTL_AN_EN];
	assign adv.speed   = {ctrl[`ANAID_CTL_SPD_MSB], ctrl[`ANAID_CTL_SPD_LSB]};
	assign adv.duplex  = ctrl[`ANAID_CTL_DUPLEX];

	// strips the acknowledge bit, masks the forced case, asks for next pages
	anaid_former i_anaid_former
	(
		.adv (adv.former)
	);

	////////////////////////////////////////////////////////////////
	// registered view of the formed advertisement
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			base_word_out <= 16'h0000;
			gig_adv_out   <= 2'h0;
			forced_out    <= 1'b0;
		end
		else
		begin
			base_word_out <= adv.base_word;
			gig_adv_out   <= adv.gig_adv;
			forced_out    <= adv.forced;
		end
	end

	// one pulse per applied update, and software reset to the core
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			applied_out <= 1'b0;
			swrst_out   <= 1'b0;
		end
		else
		begin
			applied_out <= apply_all;
			swrst_out   <= swrst_pulse;
		end
	end

	////////////////////////////////////////////////////////////////
	// page sequencer: base page, then the gigabit message and
	// unformatted pages, then software's own pages take over
	always_comb
	begin
		next_pg_state = pg_state;
		next_tx_word  = 16'h0000;
		case (pg_state)
			anaid_pkg::anaid_pg_base:
			begin
				next_tx_word = adv.base_word;
				if (adv.gig_adv != 2'h0)
					next_pg_state = anaid_pkg::anaid_pg_msg;
				else
					next_pg_state = anaid_pkg::anaid_pg_sw;
			end
			anaid_pkg::anaid_pg_msg:
			begin
				next_tx_word = {5'h00, `ANAID_PG_MSG_GIG};
				next_tx_word[`ANAID_ADV_NP] = 1'b1;
				next_tx_word[`ANAID_PG_MP]  = 1'b1;
				next_pg_state = anaid_pkg::anaid_pg_unf;
			end
			anaid_pkg::anaid_pg_unf:
			begin
				// more pages follow only if software asked for them
				next_tx_word = 16'h0000;
				next_tx_word[`ANAID_ADV_NP]    = act_adv[`ANAID_ADV_NP];
				next_tx_word[`ANAID_PG_UNF_FD] = adv.gig_adv[1];
				next_tx_word[`ANAID_PG_UNF_HD] = adv.gig_adv[0];
				next_pg_state = anaid_pkg::anaid_pg_sw;
			end
			anaid_pkg::anaid_pg_sw:
			begin
				// null page: software's pages go through the core
				next_tx_word = {3'h0, 2'h0, 11'h001};
				next_pg_state = anaid_pkg::anaid_pg_sw;
			end
			default:
			begin
				next_tx_word  = 16'h0000;
				next_pg_state = anaid_pkg::anaid_pg_base;
			end
		endcase
	end

	// a new negotiation starts from the base page again
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pg_state <= anaid_pkg::anaid_pg_base;
		else if (apply_all)
			pg_state <= anaid_pkg::anaid_pg_base;
		else if (page_req_in)
			pg_state <= next_pg_state;
	end

	// answer one cycle after the request; an apply in that cycle swallows it
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tx_word_out  <= 16'h0000;
			tx_valid_out <= 1'b0;
		end
		else
		begin
			tx_valid_out <= page_req_in && !apply_all;
			if (page_req_in && !apply_all)
				tx_word_out <= next_tx_word;
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux; unmapped offsets read zero
	// the advertisement reads back what was written, not what is active
	always_comb
	begin
		next_rd = 16'h0000;
		if (hit(addr_in, `ANAID_OFF_CTRL))
			next_rd = ctrl;
		else if (hit(addr_in, `ANAID_OFF_ID2))
			next_rd = {VENDOR_LOW, MODEL, REVISION};
		else if (hit(addr_in, `ANAID_OFF_ADV))
			next_rd = wr_adv;
		else if (hit(addr_in, `ANAID_OFF_GIG))
			next_rd[`ANAID_GIG_LSB +: 2] = wr_gig;
		else if (hit(addr_in, `ANAID_OFF_STAT))
		begin
			next_rd[`ANAID_ST_LINK]   = link_sync;
			next_rd[`ANAID_ST_PEND]   = pending;
			next_rd[`ANAID_ST_FORCED] = adv.forced;
		end
	end

	// data stand only in the cycle after the read strobe
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rd_data_out <= 16'h0000;
		else if (rd_in)
			rd_data_out <= next_rd;
		else
			rd_data_out <= 16'h0000;
	end
endmodule
`default_nettype wire

/* test/anaid_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module anaid_assertions
#(
	parameter logic [5:0] VENDOR_LOW = 6'h2A, // arbitrary value
	parameter logic [5:0] MODEL      = 6'h15, // arbitrary value
	parameter logic [3:0] REVISION   = 4'h1   // arbitrary value
)
(
	input wire logic        clk_in,
	input wire logic        rst_n_in,
	input wire logic [4:0]  addr_in,
	input wire logic [15:0] wr_data_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [15:0] rd_data_out,
	input wire logic        copper_link_in,
	input wire logic        page_req_in,
	input wire logic [15:0] tx_word_out,
	input wire logic        tx_valid_out,
	input wire logic [15:0] base_word_out,
	input wire logic [1:0]  gig_adv_out,
	input wire logic        forced_out,
	input wire logic        applied_out,
	input wire logic        swrst_out
);
	////////////////////////////////////////////////////////////////
	// one clock domain, so clock and reset are given once
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////////////////////////////
	// read port: data only in the cycle after the strobe
	a_rd_idle_zero: assert property (!$past(rd_in) |-> rd_data_out == 16'h0000)
		else $error("read data not zero outside answer cycle");
	a_id_value: assert property ($past(rd_in) && $past(addr_in) == 5'h03
		|-> rd_data_out == {VENDOR_LOW, MODEL, REVISION})
		else $error("identifier word wrong");
	a_adv_ack_zero: assert property ($past(rd_in) && $past(addr_in) == 5'h04
		|-> rd_data_out[14] == 1'b0)
		else $error("acknowledge bit read as one");

	////////////////////////////////////////////////////////////////
	// formed advertisement and page answers
	a_tx_cause: assert property (!page_req_in |=> !tx_valid_out)
		else $error("page answer without request");
	a_np_with_gig: assert property (gig_adv_out != 2'h0 |-> base_word_out[15])
		else $error("next page missing while gigabit advertised");
	a_base_ack_zero: assert property (base_word_out[14] == 1'b0)
		else $error("acknowledge set in base word");
	a_forced_gig: assert property (forced_out |-> $onehot(gig_adv_out))
		else $error("forced mode must offer exactly one duplex");
	a_forced_mask: assert property (forced_out |-> base_word_out[8:5] == 4'h0)
		else $error("forced mode kept 10/100 abilities");
	a_swrst_pulse: assert property (swrst_out |=> !swrst_out)
		else $error("software reset pulse too long");
	a_swrst_applies: assert property (swrst_out |-> applied_out)
		else $error("software reset did not apply pending values");
endmodule
`default_nettype wire

/* test/tb_anaid_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_anaid_regs;
	logic        clk_in;
	logic        rst_n_in;
	logic [4:0]  addr_in;
	logic [15:0] wr_data_in;
	logic        wr_in;
	logic        rd_in;
	logic        copper_link_in;
	logic        page_req_in;
	logic [15:0] rd_data_out;
	logic [15:0] tx_word_out;
	logic        tx_valid_out;
	logic [15:0] base_word_out;
	logic [1:0]  gig_adv_out;
	logic        forced_out;
	logic        applied_out;
	logic        swrst_out;
	int          n_fail;
	int          checked;
	localparam logic [15:0] ID_WORD = {6'h2A, 6'h15, 4'h1};

	anaid_regs #(.VENDOR_LOW(6'h2A), .MODEL(6'h15), .REVISION(4'h1)) i_anaid_regs
	(
		.clk_in         (clk_in),
		.rst_n_in       (rst_n_in),
		.addr_in        (addr_in),
		.wr_data_in     (wr_data_in),
		.wr_in          (wr_in),
		.rd_in          (rd_in),
		.rd_data_out    (rd_data_out),
		.copper_link_in (copper_link_in),
		.page_req_in    (page_req_in),
		.tx_word_out    (tx_word_out),
		.tx_valid_out   (tx_valid_out),
		.base_word_out  (base_word_out),
		.gig_adv_out    (gig_adv_out),
		.forced_out     (forced_out),
		.applied_out    (applied_out),
		.swrst_out      (swrst_out)
	);

	////////////////////////////////////////////////////////////////
	// 200 MHz clock
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("mismatch %s expected %h seen %h", nm, exp, got);
			n_fail++;
		end
	endtask

	// bus cycles: strobe for one cycle, read data land one cycle later
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_in);
		wr_in      <= 1'b1;
		addr_in    <= a;
		wr_data_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] exp, input string nm);
		@(posedge clk_in);
		rd_in   <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(nm, exp, rd_data_out);
	endtask

	// bounded wait for the apply pulse; the sync stages make link loss slow
	// the formed word follows the active copy one edge after the pulse
	task automatic wait_apply(input logic sw);
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clk_in);
			#1;
			if (applied_out === 1'b1)
			begin
				chk("swrst_out", {15'h0000, sw}, {15'h0000, swrst_out});
				@(posedge clk_in);
				#1;
				return;
			end
		end
		$display("mismatch applied_out expected 1 seen 0");
		n_fail++;
		conclude();
	endtask

	task automatic preq(input logic [15:0] mask, input logic [15:0] exp);
		@(posedge clk_in);
		page_req_in <= 1'b1;
		@(posedge clk_in);
		page_req_in <= 1'b0;
		#1;
		chk("tx_valid", 16'h0001, {15'h0000, tx_valid_out});
		chk("tx_word", exp, tx_word_out & mask);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(5'h04, 16'h0100, "adv reset");
		rd(5'h03, ID_WORD, "id word");
		wr(5'h03, 16'h0000);
		rd(5'h03, ID_WORD, "id after write");
		rd(5'h1F, 16'h0000, "unmapped");
		chk("base reset", 16'h8100, base_word_out);
		$display("test reset done");
	endtask

	task automatic t_restart();
		wr(5'h04, 16'hFFFF);
		rd(5'h04, 16'hBF00, "adv masked");
		chk("base held", 16'h8100, base_word_out);
		rd(5'h11, 16'h0002, "status pending");
		wr(5'h00, 16'h1340);
		wait_apply(1'b0);
		chk("base restart", 16'hBF00, base_word_out);
		rd(5'h11, 16'h0000, "status applied");
		$display("test restart done");
	endtask

	// software reset keeps the old 100BASE-T4 bit
	task automatic t_swrst();
		wr(5'h04, 16'h0000);
		wr(5'h00, 16'h9140);
		wait_apply(1'b1);
		chk("base swrst", 16'h8200, base_word_out);
		rd(5'h04, 16'h0000, "adv after swrst");
		$display("test swrst done");
	endtask

	task automatic t_link();
		@(posedge clk_in);
		copper_link_in <= 1'b1;
		wr(5'h04, 16'h0C00);
		rd(5'h04, 16'h0C00, "adv pause");
		rd(5'h11, 16'h0003, "status link");
		chk("base held", 16'h8200, base_word_out);
		@(posedge clk_in);
		copper_link_in <= 1'b0;
		wait_apply(1'b0);
		chk("base link", 16'h8C00, base_word_out);
		$display("test link done");
	endtask

	task automatic t_pwrdn();
		wr(5'h04, 16'h1100);
		wr(5'h00, 16'h1940);
		wr(5'h00, 16'h1140);
		wait_apply(1'b0);
		chk("base power up", 16'h9100, base_word_out);
		$display("test power done");
	endtask

	// base, message page, unformatted page, then one null page
	task automatic t_pages();
		preq(16'hFFFF, 16'h9100);
		preq(16'hFFFF, 16'hA008);
		preq(16'h8018, 16'h0018);
		preq(16'hFFFF, 16'h0001);
		$display("test pages done");
	endtask

	// forced 1000 offers one gigabit duplex whatever the gigabit bits hold
	task automatic t_forced();
		wr(5'h00, 16'h0140);
		wr(5'h09, 16'h0000);
		rd(5'h11, 16'h0006, "status forced");
		chk("gig fd", 16'h0002, {14'h0000, gig_adv_out});
		chk("base forced", 16'h9000, base_word_out);
		chk("forced_out", 16'h0001, {15'h0000, forced_out});
		wr(5'h00, 16'h0040);
		rd(5'h11, 16'h0006, "status forced hd");
		chk("gig hd", 16'h0001, {14'h0000, gig_adv_out});
		wr(5'h00, 16'h2100);
		rd(5'h09, 16'h0000, "gig written");
		chk("gig unforced", 16'h0003, {14'h0000, gig_adv_out});
		chk("base unforced", 16'h9100, base_word_out);
		chk("forced_out off", 16'h0000, {15'h0000, forced_out});
		$display("test forced done");
	endtask

	////////////////////////////////////////////////////////////////
	// reset for eight cycles, then the scenarios in order
	initial
	begin
		n_fail = 0;
		checked = 0;
		rst_n_in = 1'b0;
		addr_in = 5'h00;
		wr_data_in = 16'h0000;
		wr_in = 1'b0;
		rd_in = 1'b0;
		copper_link_in = 1'b0;
		page_req_in = 1'b0;
		repeat (8) @(posedge clk_in);
		rst_n_in <= 1'b1;
		t_reset();
		t_restart();
		t_swrst();
		t_link();
		t_pwrdn();
		t_pages();
		t_forced();
		conclude();
	end
endmodule

bind anaid_regs anaid_assertions #(.VENDOR_LOW(VENDOR_LOW), .MODEL(MODEL),
	.REVISION(REVISION)) i_anaid_assertions
(
	.clk_in         (clk_in),
	.rst_n_in       (rst_n_in),
	.addr_in        (addr_in),
	.wr_data_in     (wr_data_in),
	.wr_in          (wr_in),
	.rd_in          (rd_in),
	.rd_data_out    (rd_data_out),
	.copper_link_in (copper_link_in),
	.page_req_in    (page_req_in),
	.tx_word_out    (tx_word_out),
	.tx_valid_out   (tx_valid_out),
	.base_word_out  (base_word_out),
	.gig_adv_out    (gig_adv_out),
	.forced_out     (forced_out),
	.applied_out    (applied_out),
	.swrst_out      (swrst_out)
);
`default_nettype wire
